// *** jcp_pkg.sv ***
// Function
// - JTAG configuration overrides every other scheme
// - JTAG start aborts passive serial load
// - No config clock in active serial during JTAG
// - Four dedicated pins: TDI TDO TMS TCK
// - User I/O tri-stated during JTAG configuration
// - TDI sampled on rising TCK
// - TDO updated on falling TCK
// - TDO tri-stated unless shifting out
// - TMS evaluated, TAP advances on rising TCK
// - Bypass uses single-bit register, no side effects
// - Bypass data appears one TCK later
// - Raise config-complete at end of JTAG load
// - BYPASS, IDCODE, SAMPLE do not interrupt loading
package jcp_pkg;
    localparam int IR_W = 10;
    localparam int ID_W = 32;
    localparam int CFG_LEN_W = 16;
    localparam logic [CFG_LEN_W-1:0] CFG_LEN = 16'h0040;
    localparam logic [IR_W-1:0] IR_BYPASS = 10'h3ff;
    localparam logic [IR_W-1:0] IR_IDCODE = 10'h006;
    localparam logic [IR_W-1:0] IR_SAMPLE = 10'h005;
    localparam logic [IR_W-1:0] IR_PROGRAM = 10'h002;
    localparam logic [IR_W-1:0] IR_STARTUP = 10'h003;
    localparam logic [IR_W-1:0] IR_CAPTURE = 10'h001;
    // Identity value is arbitrary
    localparam logic [ID_W-1:0] ID_VALUE = 32'h0a5a5001;
    localparam logic [1:0] SCHEME_PS = 2'h0;
    localparam logic [1:0] SCHEME_AS = 2'h1;

    typedef enum logic [3:0] {
        TAP_RESET = 4'h0,
        TAP_IDLE = 4'h1,
        TAP_DR_SEL = 4'h3,
        TAP_DR_CAP = 4'h2,
        TAP_DR_SHIFT = 4'h6,
        TAP_DR_EXIT1 = 4'h7,
        TAP_DR_PAUSE = 4'h5,
        TAP_DR_EXIT2 = 4'h4,
        TAP_DR_UPD = 4'hc,
        TAP_IR_SEL = 4'hd,
        TAP_IR_CAP = 4'hf,
        TAP_IR_SHIFT = 4'he,
        TAP_IR_EXIT1 = 4'ha,
        TAP_IR_PAUSE = 4'hb,
        TAP_IR_EXIT2 = 4'h9,
        TAP_IR_UPD = 4'h8
    } jcp_tap_t;

    typedef struct packed {
        logic tdi;
        logic tms;
    } jcp_link_in_t;

    typedef struct packed {
        logic tdo;
        logic tdoOe;
    } jcp_link_out_t;
endpackage : jcp_pkg

// *** jcp_config_port.sv ***
`timescale 1ns/1ps
// Two flops; only the second one is read outside
module jcp_sync
    import jcp_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } jcp_sync_t;

    jcp_sync_t r;
    jcp_sync_t next_r;

    always_comb
    begin
        next_r = r;
        next_r.meta = d;
        next_r.stable = r.meta;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign q = r.stable;
endmodule : jcp_sync

module jcp_config_port
    import jcp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tck,
    input wire jcp_link_in_t linkIn,
    output jcp_link_out_t linkOut,
    input wire logic [1:0] scheme_select,
    input wire logic passiveSerialActive,
    output logic passiveSerialAbort,
    output logic configClkEnable,
    output logic userIoTristate,
    output logic configDone,
    output logic [7:0] configByte,
    output logic configByteValid
);
    // TCK domain state; reset through arst_n, and only tap, ir and loading through TMS as well
    typedef struct packed {
        jcp_tap_t tap;
        logic [IR_W-1:0] irShift;
        logic [IR_W-1:0] ir;
        logic [ID_W-1:0] drShift;
        logic bypass;
        logic loading;
        logic done;
        logic [CFG_LEN_W-1:0] bitCnt;
        logic [7:0] byteShift;
        logic [7:0] byteHold;
        logic byteToggle;
    } jcp_tck_t;

    typedef struct packed {
        logic togglePrev;
        logic [7:0] cfgByte;
        logic cfgValid;
        logic abort;
        logic clkEn;
        logic ioTri;
        logic done;
    } jcp_sys_t;

    jcp_tck_t t;
    jcp_tck_t next_t;
    jcp_sys_t s;
    jcp_sys_t next_s;
    jcp_link_out_t o;
    jcp_link_out_t next_o;
    logic loadSeen;
    logic toggleSeen;
    logic doneSeen;
    logic [1:0] schemeSeen;

    always_comb
    begin
        next_t = t;
        // Next TAP state
        case (t.tap)
            TAP_RESET: next_t.tap = linkIn.tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_t.tap = linkIn.tms ? TAP_DR_SEL : TAP_IDLE;
            TAP_DR_SEL: next_t.tap = linkIn.tms ? TAP_IR_SEL : TAP_DR_CAP;
            TAP_DR_CAP: next_t.tap = linkIn.tms ? TAP_DR_EXIT1 : TAP_DR_SHIFT;
            TAP_DR_SHIFT: next_t.tap = linkIn.tms ? TAP_DR_EXIT1 : TAP_DR_SHIFT;
            TAP_DR_EXIT1: next_t.tap = linkIn.tms ? TAP_DR_UPD : TAP_DR_PAUSE;
            TAP_DR_PAUSE: next_t.tap = linkIn.tms ? TAP_DR_EXIT2 : TAP_DR_PAUSE;
            TAP_DR_EXIT2: next_t.tap = linkIn.tms ? TAP_DR_UPD : TAP_DR_SHIFT;
            TAP_DR_UPD: next_t.tap = linkIn.tms ? TAP_DR_SEL : TAP_IDLE;
            TAP_IR_SEL: next_t.tap = linkIn.tms ? TAP_RESET : TAP_IR_CAP;
            TAP_IR_CAP: next_t.tap = linkIn.tms ? TAP_IR_EXIT1 : TAP_IR_SHIFT;
            TAP_IR_SHIFT: next_t.tap = linkIn.tms ? TAP_IR_EXIT1 : TAP_IR_SHIFT;
            TAP_IR_EXIT1: next_t.tap = linkIn.tms ? TAP_IR_UPD : TAP_IR_PAUSE;
            TAP_IR_PAUSE: next_t.tap = linkIn.tms ? TAP_IR_EXIT2 : TAP_IR_PAUSE;
            TAP_IR_EXIT2: next_t.tap = linkIn.tms ? TAP_IR_UPD : TAP_IR_SHIFT;
            TAP_IR_UPD: next_t.tap = linkIn.tms ? TAP_DR_SEL : TAP_IDLE;
            default: next_t.tap = TAP_RESET;
        endcase

        case (t.tap)
            TAP_RESET:
            begin
                next_t.ir = IR_IDCODE;
                next_t.loading = 1'b0;
            end
            TAP_IR_CAP: next_t.irShift = IR_CAPTURE;
            TAP_IR_SHIFT: next_t.irShift = {linkIn.tdi, t.irShift[IR_W-1:1]};
            TAP_IR_UPD:
            begin
                next_t.ir = t.irShift;
                // Loading starts at any time; other schemes yield
                if (t.irShift == IR_PROGRAM)
                begin
                    next_t.loading = 1'b1;
                    next_t.done = 1'b0;
                    next_t.bitCnt = '0;
                end
            end
            TAP_DR_CAP:
            begin
                if (t.ir == IR_IDCODE)
                    next_t.drShift = ID_VALUE;
                else
                    next_t.drShift = '0;
                next_t.bypass = 1'b0;
            end
            TAP_DR_SHIFT:
            begin
                // Bypass touches nothing else
                if (t.ir == IR_PROGRAM && t.loading)
                begin
                    next_t.byteShift = {linkIn.tdi, t.byteShift[7:1]};
                    next_t.bitCnt = t.bitCnt + 1'b1;
                    if (t.bitCnt[2:0] == 3'h7)
                    begin
                        next_t.byteHold = {linkIn.tdi, t.byteShift[7:1]};
                        next_t.byteToggle = ~t.byteToggle;
                    end
                end
                else if (t.ir == IR_IDCODE || t.ir == IR_SAMPLE)
                    next_t.drShift = {linkIn.tdi, t.drShift[ID_W-1:1]};
                else
                    next_t.bypass = linkIn.tdi;
            end
            TAP_IDLE:
            begin
                if (t.ir == IR_STARTUP && t.loading && t.bitCnt >= CFG_LEN)
                begin
                    next_t.loading = 1'b0;
                    next_t.done = 1'b1;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge tck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            t <= '{tap: TAP_RESET, ir: IR_IDCODE, default: '0};
        end
        else
        begin
            t <= next_t;
        end
    end

    // Output bit is chosen from the state settled at the last rising edge
    always_comb
    begin
        next_o = o;
        next_o.tdoOe = (t.tap == TAP_DR_SHIFT) || (t.tap == TAP_IR_SHIFT);
        if (t.tap == TAP_IR_SHIFT)
            next_o.tdo = t.irShift[0];
        else if (t.ir == IR_IDCODE || t.ir == IR_SAMPLE)
            next_o.tdo = t.drShift[0];
        else if (t.ir == IR_PROGRAM)
            next_o.tdo = 1'b0;
        else
            next_o.tdo = t.bypass;
    end

    // TDO changes on the falling edge only
    always_ff @(negedge tck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            o <= '0;
        end
        else
        begin
            o <= next_o;
        end
    end

    assign linkOut = o;

    // System clock side; each TCK side flag passes two flops
    jcp_sync
    #(
        .W(1)
    )
    u_jcp_sync_load
    (
        .clk(clk),
        .arst_n(arst_n),
        .d(t.loading),
        .q(loadSeen)
    );

    jcp_sync
    #(
        .W(1)
    )
    u_jcp_sync_toggle
    (
        .clk(clk),
        .arst_n(arst_n),
        .d(t.byteToggle),
        .q(toggleSeen)
    );

    jcp_sync
    #(
        .W(1)
    )
    u_jcp_sync_done
    (
        .clk(clk),
        .arst_n(arst_n),
        .d(t.done),
        .q(doneSeen)
    );

    // Strap pins are asynchronous to clk as well
    jcp_sync
    #(
        .W(2)
    )
    u_jcp_sync_scheme
    (
        .clk(clk),
        .arst_n(arst_n),
        .d(scheme_select),
        .q(schemeSeen)
    );

    always_comb
    begin
        next_s = s;
        next_s.togglePrev = toggleSeen;
        next_s.cfgValid = toggleSeen ^ s.togglePrev;
        // Word is steady long before its toggle arrives here
        if (toggleSeen ^ s.togglePrev)
            next_s.cfgByte = t.byteHold;
        // Passive serial loader is told to give up
        next_s.abort = loadSeen && passiveSerialActive
            && schemeSeen == SCHEME_PS;
        next_s.clkEn = !(loadSeen && schemeSeen == SCHEME_AS);
        next_s.ioTri = loadSeen;
        next_s.done = doneSeen;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s <= '{clkEn: 1'b1, default: '0};
        end
        else
        begin
            s <= next_s;
        end
    end

    // Held byte stands for eight TCK bits after its toggle
    assign passiveSerialAbort = s.abort;
    assign configClkEnable = s.clkEn;
    assign userIoTristate = s.ioTri;
    assign configDone = s.done;
    assign configByte = s.cfgByte;
    assign configByteValid = s.cfgValid;
endmodule : jcp_config_port

// *** jcp_config_port_assertions.sv ***
`timescale 1ns/1ps
module jcp_config_port_assertions
    import jcp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tck,
    input wire jcp_link_in_t linkIn,
    input wire jcp_link_out_t linkOut,
    input wire logic [1:0] scheme_select,
    input wire logic passiveSerialActive,
    input wire logic passiveSerialAbort,
    input wire logic configClkEnable,
    input wire logic userIoTristate,
    input wire logic configDone,
    input wire logic [7:0] configByte,
    input wire logic configByteValid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_abort_scheme: assert property (passiveSerialAbort
        |-> $past(scheme_select, 3) == SCHEME_PS)
        else $error("abort outside passive serial");
    a_abort_load: assert property (passiveSerialAbort |-> userIoTristate)
        else $error("abort without load");
    a_as_quiet: assert property (userIoTristate
        && $past(scheme_select, 3) == SCHEME_AS |-> !configClkEnable)
        else $error("config clock during load");
    a_tdo_edge: assert property ($changed(linkOut.tdo) |-> !tck)
        else $error("tdo moved with tck high");
    a_byte_pulse: assert property (configByteValid |=> !configByteValid)
        else $error("byte strobe too long");
    a_byte_load: assert property (configByteValid |-> userIoTristate)
        else $error("byte outside load");
    a_done_ends: assert property ($rose(configDone) |-> !userIoTristate)
        else $error("done while pins tristated");
    a_done_holds: assert property ($rose(configDone) |=> configDone [*8])
        else $error("done dropped");
    cover property (configByteValid);
    cover property ($rose(configDone));
    cover property (passiveSerialAbort);
endmodule : jcp_config_port_assertions
bind jcp_config_port jcp_config_port_assertions u_chk (.clk(clk), .arst_n(arst_n), .tck(tck),
    .linkIn(linkIn), .linkOut(linkOut), .scheme_select(scheme_select),
    .passiveSerialActive(passiveSerialActive), .passiveSerialAbort(passiveSerialAbort),
    .configClkEnable(configClkEnable), .userIoTristate(userIoTristate),
    .configDone(configDone), .configByte(configByte), .configByteValid(configByteValid));

// *** jcp_host_model.sv ***
`timescale 1ns/1ps
module jcp_host_model
    import jcp_pkg::*;
(
    output logic tck,
    output jcp_link_in_t linkIn,
    input wire jcp_link_out_t linkOut
);
    logic lastTdo;
    // Pull-ups on the inputs, clock parked low between frames
    initial
    begin
        tck = 1'b0;
        linkIn = '1;
    end
    task automatic step(input logic ms, input logic di);
        linkIn.tms = ms;
        linkIn.tdi = di;
        #80;
        lastTdo = linkOut.tdoOe ? linkOut.tdo : 1'bz;
        tck = 1'b1;
        #80;
        tck = 1'b0;
    endtask : step
    task automatic scan(input logic ir, input logic [63:0] d, input int n,
        output logic [63:0] q);
        q = '0;
        step(1'b1, 1'b1);
        if (ir)
            step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, d[i]);
            q[i] = lastTdo;
        end
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        linkIn = '1;
    endtask : scan
    task automatic tapReset();
        for (int i = 0; i < 5; i++)
            step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask : tapReset
endmodule : jcp_host_model

// *** jcp_config_port_test.sv ***
`timescale 1ns/1ps
module jcp_config_port_test
    import jcp_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic tck;
    jcp_link_in_t linkIn;
    jcp_link_out_t linkOut;
    logic [1:0] scheme_select = SCHEME_PS;
    logic chipEnable_n = 1'b0;
    logic passiveSerialActive = 1'b0;
    logic passiveSerialAbort, configClkEnable, userIoTristate, configDone, configByteValid;
    logic [7:0] configByte, firstByte;
    logic [63:0] q;
    int errCount = 0, checks = 0, nBytes = 0;
    always #2.5 clk = ~clk;
    jcp_config_port u_jcp_config_port (.clk(clk), .arst_n(arst_n), .tck(tck),
        .linkIn(linkIn), .linkOut(linkOut), .scheme_select(scheme_select),
        .passiveSerialActive(passiveSerialActive), .passiveSerialAbort(passiveSerialAbort),
        .configClkEnable(configClkEnable), .userIoTristate(userIoTristate),
        .configDone(configDone), .configByte(configByte), .configByteValid(configByteValid));
    jcp_host_model u_jcp_host_model (.tck(tck), .linkIn(linkIn), .linkOut(linkOut));
    always @(negedge clk)
        if (configByteValid)
        begin
            if (nBytes == 0)
                firstByte = configByte;
            nBytes++;
        end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            errCount++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Flags cross into clk three cycles late
    task automatic settle();
        repeat (4) @(negedge clk);
    endtask : settle
    task automatic t_idcode();
        u_jcp_host_model.tapReset();
        u_jcp_host_model.scan(1'b0, '0, 32, q);
        chk(q, 64'(ID_VALUE));
        chk(64'(linkOut.tdoOe), 64'h0);
        $display("idcode test done");
    endtask : t_idcode
    task automatic t_bypass();
        u_jcp_host_model.scan(1'b1, 64'(IR_BYPASS), IR_W, q);
        u_jcp_host_model.scan(1'b0, 64'h00a5, 9, q);
        chk(q, 64'h014a);
        chk(64'(userIoTristate), 64'h0);
        $display("bypass test done");
    endtask : t_bypass
    task automatic t_load();
        @(negedge clk);
        passiveSerialActive = 1'b1;
        u_jcp_host_model.scan(1'b1, 64'(IR_PROGRAM), IR_W, q);
        settle();
        chk(64'({passiveSerialAbort, userIoTristate}), 64'h3);
        u_jcp_host_model.scan(1'b0, 64'h0123_4567_89ab_cdef, 64, q);
        u_jcp_host_model.scan(1'b1, 64'(IR_IDCODE), IR_W, q);
        u_jcp_host_model.scan(1'b0, '0, 32, q);
        chk(q, 64'(ID_VALUE));
        u_jcp_host_model.scan(1'b1, 64'(IR_SAMPLE), IR_W, q);
        u_jcp_host_model.scan(1'b1, 64'(IR_STARTUP), IR_W, q);
        u_jcp_host_model.step(1'b0, 1'b1);
        settle();
        chk(64'({configDone, userIoTristate}), 64'h2);
        chk(64'({nBytes[3:0], firstByte}), 64'h8ef);
        passiveSerialActive = 1'b0;
        $display("load test done");
    endtask : t_load
    task automatic t_active();
        scheme_select = SCHEME_AS;
        settle();
        chk(64'(configClkEnable), 64'h1);
        u_jcp_host_model.scan(1'b1, 64'(IR_PROGRAM), IR_W, q);
        settle();
        chk(64'({configClkEnable, configDone}), 64'h0);
        u_jcp_host_model.tapReset();
        u_jcp_host_model.scan(1'b0, '0, 32, q);
        chk(q, 64'(ID_VALUE));
        $display("active test done");
    endtask : t_active
    task automatic final_report();
        $display("checks=%0d errors=%0d", checks, errCount);
        if (errCount == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        #1.3;
        t_idcode();
        t_bypass();
        t_load();
        t_active();
        final_report();
    end
    initial
    begin
        #200us;
        errCount++;
        final_report();
    end
endmodule : jcp_config_port_test
